// *** sdram_device_end.sv ***
// DRAM end of the pin link: command decode, bank states, mode word and
// a small storage array with masked burst reads and writes.
// Assumes the controller runs on the same clock and keeps its own timing.
//
// Operation
// - Two bank select bits pick one of four banks.
// - Row-open captures all twelve address lines as row.
// - Column on low nine lines, bit ten auto-close.
// - Precharge: bit ten high closes all banks.
// - Mode-load takes settings from the address lines.
// - Commands act only while chip select sampled low.
// - Strobes sampled and decoded at rising edges only.
// - Row strobe low, column and write high: row-open.
// - Row and write low, column high: precharge bank.
// - Column strobe low, row high: read or write.
// - Byte masks gate read drive and write storage.
// - Sixteen-bit data moves on rising clock edges.
// - Read mask takes effect two clocks after sampling.
`timescale 1ns/1ps
`include "sdram_pins_params.svh"
module sdram_device_end
    import sdram_pins_pkg::*;
#(
    parameter int ROW_KEEP_BITS = 2,
    parameter int COL_BITS = `COL_WIDTH
)
(
    input wire logic clk,
    input wire logic resetn,
    sdram_pins_if.device pins,
    output logic [`BANK_COUNT-1:0] bank_open,
    output logic [`ADDR_WIDTH-1:0] mode_word,
    output logic cmd_seen
);
    localparam int MEM_ABITS = `BANK_WIDTH + ROW_KEEP_BITS + COL_BITS;
    localparam logic [3:0] CLOSE_CYCLES = 4'(`PRECHARGE_CYCLES);

    // ------------------------------------------------------------
    // Command decode
    // ------------------------------------------------------------
    logic sel;
    logic is_open;
    logic is_close;
    logic is_col;
    logic is_rd;
    logic is_wr;
    logic is_mode;
    logic [1:0] bank;
    logic close_all;

    assign sel = !pins.cs_n;
    assign is_open = sel && !pins.ras_n && pins.cas_n && pins.we_n;
    assign is_close = sel && !pins.ras_n && pins.cas_n && !pins.we_n;
    assign is_col = sel && pins.ras_n && !pins.cas_n;
    assign is_rd = is_col && pins.we_n;
    assign is_wr = is_col && !pins.we_n;
    assign is_mode = sel && !pins.ras_n && !pins.cas_n && !pins.we_n;
    assign bank = pins.bank_select;
    assign close_all = pins.address_lines[`AUTO_CLOSE_BIT];

    // ------------------------------------------------------------
    // Mode word
    // ------------------------------------------------------------
    logic [`ADDR_WIDTH-1:0] mode_ff;
    logic [3:0] bl;
    logic [2:0] cl;

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            mode_ff <= `MODE_RESET;
        end
        else if (is_mode)
        begin
            mode_ff <= pins.address_lines;
        end
    end

    assign bl = burst_words(mode_ff);
    assign cl = read_latency(mode_ff);
    assign mode_word = mode_ff;

    // ------------------------------------------------------------
    // Burst tracking
    // ------------------------------------------------------------
    bank_state_t state_ff [`BANK_COUNT];
    logic [`ADDR_WIDTH-1:0] row_ff [`BANK_COUNT];
    logic [3:0] close_cnt_ff [`BANK_COUNT];
    logic [2:0] rd_pend_ff;
    logic [3:0] rd_left_ff;
    logic [3:0] wr_left_ff;
    logic [1:0] burst_bank_ff;
    logic [COL_BITS-1:0] burst_col_ff;
    logic burst_ac_ff;
    logic col_go;
    logic wr_fire;
    logic rd_fire;
    logic last_wr;
    logic ac_go;
    logic [1:0] ac_bank;
    logic [1:0] acc_bank;
    logic [COL_BITS-1:0] acc_col;
    logic [MEM_ABITS-1:0] acc_addr;

    // Column commands to a bank that is not open are ignored.
    assign col_go = is_col && (state_ff[bank] == BANK_ACTIVE);
    assign wr_fire = (col_go && is_wr) || (!col_go && wr_left_ff != 4'h0);
    assign rd_fire = !col_go && rd_pend_ff == 3'h0 && rd_left_ff != 4'h0;
    assign last_wr = col_go ? (bl == 4'h1) : (wr_left_ff == 4'h1);
    assign acc_bank = col_go ? bank : burst_bank_ff;
    assign acc_col = col_go ? pins.address_lines[COL_BITS-1:0] : burst_col_ff;
    assign acc_addr = {acc_bank, row_ff[acc_bank][ROW_KEEP_BITS-1:0], acc_col};
    assign ac_bank = acc_bank;
    assign ac_go = (wr_fire && last_wr &&
        (col_go ? pins.address_lines[`AUTO_CLOSE_BIT] : burst_ac_ff)) ||
        (rd_fire && rd_left_ff == 4'h1 && burst_ac_ff);

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            rd_pend_ff <= 3'h0;
            rd_left_ff <= 4'h0;
            wr_left_ff <= 4'h0;
            burst_bank_ff <= 2'h0;
            burst_col_ff <= '0;
            burst_ac_ff <= 1'b0;
        end
        else if (col_go)
        begin
            burst_bank_ff <= bank;
            burst_ac_ff <= pins.address_lines[`AUTO_CLOSE_BIT];
            if (is_rd)
            begin
                rd_pend_ff <= cl - 3'h2;
                rd_left_ff <= bl;
                wr_left_ff <= 4'h0;
                burst_col_ff <= pins.address_lines[COL_BITS-1:0];
            end
            else
            begin
                rd_left_ff <= 4'h0;
                wr_left_ff <= bl - 4'h1;
                burst_col_ff <= next_col(pins.address_lines[COL_BITS-1:0], bl);
            end
        end
        else if (rd_pend_ff != 3'h0)
        begin
            rd_pend_ff <= rd_pend_ff - 3'h1;
        end
        else if (rd_fire)
        begin
            rd_left_ff <= rd_left_ff - 4'h1;
            burst_col_ff <= next_col(burst_col_ff, bl);
        end
        else if (wr_fire)
        begin
            wr_left_ff <= wr_left_ff - 4'h1;
            burst_col_ff <= next_col(burst_col_ff, bl);
        end
    end

    // ------------------------------------------------------------
    // Bank states
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            for (int b = 0; b < `BANK_COUNT; b++)
            begin
                state_ff[b] <= BANK_IDLE;
                row_ff[b] <= '0;
                close_cnt_ff[b] <= 4'h0;
            end
        end
        else
        begin
            for (int b = 0; b < `BANK_COUNT; b++)
            begin
                if (is_open && bank == 2'(b) && state_ff[b] == BANK_IDLE)
                begin
                    state_ff[b] <= BANK_ACTIVE;
                    row_ff[b] <= pins.address_lines;
                end
                else if (is_close && (close_all || bank == 2'(b)))
                begin
                    if (state_ff[b] == BANK_ACTIVE)
                    begin
                        state_ff[b] <= BANK_CLOSING;
                        close_cnt_ff[b] <= CLOSE_CYCLES;
                    end
                end
                else if (ac_go && ac_bank == 2'(b))
                begin
                    state_ff[b] <= BANK_CLOSING;
                    close_cnt_ff[b] <= CLOSE_CYCLES;
                end
                else if (state_ff[b] == BANK_CLOSING)
                begin
                    close_cnt_ff[b] <= close_cnt_ff[b] - 4'h1;
                    if (close_cnt_ff[b] <= 4'h1)
                    begin
                        state_ff[b] <= BANK_IDLE;
                    end
                end
            end
        end
    end

    always_comb
    begin
        for (int b = 0; b < `BANK_COUNT; b++)
        begin
            bank_open[b] = (state_ff[b] == BANK_ACTIVE);
        end
    end

    // ------------------------------------------------------------
    // Storage and data pins
    // ------------------------------------------------------------
    logic [`DATA_WIDTH-1:0] mem [2**MEM_ABITS];
    logic [1:0] mask_s_ff;
    logic [`DATA_WIDTH-1:0] dq_out_ff;
    logic [1:0] dq_oe_n_ff;
    logic cmd_seen_ff;

    // Masked bytes are left as they were.
    always_ff @(posedge clk)
    begin
        if (wr_fire && !pins.low_byte_mask)
        begin
            mem[acc_addr][7:0] <= pins.data_io[7:0];
        end
        if (wr_fire && !pins.high_byte_mask)
        begin
            mem[acc_addr][15:8] <= pins.data_io[15:8];
        end
    end

    // The drive decided at this edge uses the mask sampled one edge ago,
    // so the host sees it at the second edge after the mask was sampled.
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            mask_s_ff <= `MASK_ALL;
            dq_out_ff <= 16'h0000;
            dq_oe_n_ff <= `MASK_ALL;
        end
        else
        begin
            mask_s_ff <= {pins.high_byte_mask, pins.low_byte_mask};
            if (rd_fire)
            begin
                dq_out_ff <= mem[acc_addr];
                dq_oe_n_ff <= mask_s_ff;
            end
            else
            begin
                dq_oe_n_ff <= `MASK_ALL;
            end
        end
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            cmd_seen_ff <= 1'b0;
        end
        else
        begin
            cmd_seen_ff <= sel && !(pins.ras_n && pins.cas_n && pins.we_n);
        end
    end

    assign pins.dev_dq_out = dq_out_ff;
    assign pins.dev_dq_oe_n = dq_oe_n_ff;
    assign cmd_seen = cmd_seen_ff;
endmodule

// *** sdram_host_end.sv ***
// Controller end of the pin link: turns user commands into pin cycles,
// streams write data out and collects read data into a FIFO.
// Assumes the user spaces commands to meet the DRAM's own timing.
`timescale 1ns/1ps
`include "sdram_pins_params.svh"
module sync_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 32
)
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data,
    output logic [$clog2(DEPTH):0] free
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wp_ff;
    logic [AW:0] rp_ff;
    logic [AW:0] used;

    assign used = wp_ff - rp_ff;
    assign free = (AW + 1)'(DEPTH) - used;
    assign in_ready = used != (AW + 1)'(DEPTH);
    assign out_valid = used != '0;
    assign out_data = mem[rp_ff[AW-1:0]];

    always_ff @(posedge clk)
    begin
        if (in_valid && in_ready)
        begin
            mem[wp_ff[AW-1:0]] <= in_data;
        end
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            wp_ff <= '0;
            rp_ff <= '0;
        end
        else
        begin
            if (in_valid && in_ready)
            begin
                wp_ff <= wp_ff + 1'b1;
            end
            if (out_valid && out_ready)
            begin
                rp_ff <= rp_ff + 1'b1;
            end
        end
    end
endmodule

module sdram_host_end
    import sdram_pins_pkg::*;
#(
    parameter int FIFO_DEPTH = 32
)
(
    input wire logic clk,
    input wire logic resetn,
    sdram_pins_if.host pins,
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire host_cmd_t cmd_kind,
    input wire logic [1:0] cmd_bank,
    input wire logic [`ADDR_WIDTH-1:0] cmd_addr,
    input wire logic [1:0] cmd_mask,
    input wire logic wr_valid,
    output logic wr_ready,
    input wire logic [`DATA_WIDTH-1:0] wr_data,
    input wire logic [1:0] wr_mask,
    output logic rd_valid,
    input wire logic rd_ready,
    output logic [`DATA_WIDTH-1:0] rd_data
);
    typedef enum {H_IDLE, H_WRITE, H_READ} host_state_t;
    host_state_t state_ff;
    logic [`ADDR_WIDTH-1:0] mode_ff;
    logic [3:0] left_ff;
    logic [2:0] wait_ff;
    logic [3:0] bl;
    logic take;
    logic push;
    logic fifo_in_ready;
    logic [$clog2(FIFO_DEPTH):0] fifo_free;
    logic [3:0] pins_cmd_ff;
    logic [1:0] bank_ff;
    logic [`ADDR_WIDTH-1:0] addr_ff;
    logic [1:0] mask_ff;
    logic [`DATA_WIDTH-1:0] dq_ff;
    logic dq_oe_n_ff;

    assign bl = burst_words(mode_ff);
    // A read waits until the FIFO can hold a whole burst.
    assign cmd_ready = state_ff == H_IDLE &&
        (cmd_kind != CMD_READ || fifo_free >= ($clog2(FIFO_DEPTH) + 1)'(`MAX_BURST));
    assign take = cmd_valid && cmd_ready;
    assign wr_ready = (take && cmd_kind == CMD_WRITE) || state_ff == H_WRITE;
    assign push = state_ff == H_READ && wait_ff == 3'h0;

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            state_ff <= H_IDLE;
            mode_ff <= `MODE_RESET;
            left_ff <= 4'h0;
            wait_ff <= 3'h0;
            pins_cmd_ff <= 4'hf;
            bank_ff <= 2'h0;
            addr_ff <= '0;
            mask_ff <= `MASK_ALL;
            dq_ff <= 16'h0000;
            dq_oe_n_ff <= 1'b1;
        end
        else
        begin
            pins_cmd_ff <= 4'hf;
            dq_oe_n_ff <= 1'b1;
            if (take)
            begin
                bank_ff <= cmd_bank;
                addr_ff <= cmd_addr;
                case (cmd_kind)
                    CMD_ROW_OPEN: pins_cmd_ff <= 4'b0011;
                    CMD_PRECHARGE:
                    begin
                        pins_cmd_ff <= 4'b0010;
                        addr_ff[`AUTO_CLOSE_BIT] <= 1'b0;
                    end
                    CMD_PRECHARGE_ALL:
                    begin
                        pins_cmd_ff <= 4'b0010;
                        addr_ff[`AUTO_CLOSE_BIT] <= 1'b1;
                    end
                    CMD_READ:
                    begin
                        pins_cmd_ff <= 4'b0101;
                        mask_ff <= cmd_mask;
                        state_ff <= H_READ;
                        wait_ff <= read_latency(mode_ff);
                        left_ff <= bl;
                    end
                    CMD_WRITE:
                    begin
                        pins_cmd_ff <= 4'b0100;
                        dq_ff <= wr_data;
                        dq_oe_n_ff <= 1'b0;
                        mask_ff <= wr_valid ? wr_mask : `MASK_ALL;
                        left_ff <= bl - 4'h1;
                        state_ff <= (bl == 4'h1) ? H_IDLE : H_WRITE;
                    end
                    CMD_MODE_LOAD:
                    begin
                        pins_cmd_ff <= 4'b0000;
                        mode_ff <= cmd_addr;
                    end
                    default: pins_cmd_ff <= 4'b0111;
                endcase
            end
            else if (state_ff == H_WRITE)
            begin
                dq_ff <= wr_data;
                dq_oe_n_ff <= 1'b0;
                mask_ff <= wr_valid ? wr_mask : `MASK_ALL;
                left_ff <= left_ff - 4'h1;
                if (left_ff == 4'h1)
                begin
                    state_ff <= H_IDLE;
                end
            end
            else if (state_ff == H_READ)
            begin
                if (wait_ff != 3'h0)
                begin
                    wait_ff <= wait_ff - 3'h1;
                end
                else
                begin
                    left_ff <= left_ff - 4'h1;
                    if (left_ff == 4'h1)
                    begin
                        state_ff <= H_IDLE;
                    end
                end
            end
        end
    end

    sync_fifo #(
        .WIDTH(`DATA_WIDTH),
        .DEPTH(FIFO_DEPTH)
    ) read_buf (
        .clk(clk),
        .resetn(resetn),
        .in_valid(push),
        .in_ready(fifo_in_ready),
        .in_data(pins.data_io),
        .out_valid(rd_valid),
        .out_ready(rd_ready),
        .out_data(rd_data),
        .free(fifo_free)
    );

    assign pins.cs_n = pins_cmd_ff[3];
    assign pins.ras_n = pins_cmd_ff[2];
    assign pins.cas_n = pins_cmd_ff[1];
    assign pins.we_n = pins_cmd_ff[0];
    assign pins.bank_select = bank_ff;
    assign pins.address_lines = addr_ff;
    assign pins.low_byte_mask = mask_ff[0];
    assign pins.high_byte_mask = mask_ff[1];
    assign pins.host_dq_out = dq_ff;
    assign pins.host_dq_oe_n = dq_oe_n_ff;
endmodule

// *** sdram_pins_if.sv ***
// Pin bundle between the memory controller end and the DRAM end.
// Resolves the shared data bus from the two sides' output enables.
`timescale 1ns/1ps
interface sdram_pins_if;
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic [1:0] bank_select;
    logic [11:0] address_lines;
    logic low_byte_mask;
    logic high_byte_mask;
    logic [15:0] host_dq_out;
    logic host_dq_oe_n;
    logic [15:0] dev_dq_out;
    logic [1:0] dev_dq_oe_n;
    logic [15:0] data_io;

    assign data_io[7:0] = !dev_dq_oe_n[0] ? dev_dq_out[7:0] :
        (!host_dq_oe_n ? host_dq_out[7:0] : 8'h00);
    assign data_io[15:8] = !dev_dq_oe_n[1] ? dev_dq_out[15:8] :
        (!host_dq_oe_n ? host_dq_out[15:8] : 8'h00);

    modport host (output cs_n, ras_n, cas_n, we_n, bank_select, address_lines,
        low_byte_mask, high_byte_mask, host_dq_out, host_dq_oe_n, input data_io);
    modport device (input cs_n, ras_n, cas_n, we_n, bank_select, address_lines,
        low_byte_mask, high_byte_mask, data_io, output dev_dq_out, dev_dq_oe_n);
endinterface

// *** sdram_pins_params.svh ***
// Constants shared by both ends of the synchronous DRAM pin link.
// Assumes a single 40 MHz clock that both ends run on.
`ifndef SDRAM_PINS_PARAMS_SVH
`define SDRAM_PINS_PARAMS_SVH
`define BANK_COUNT 4
`define BANK_WIDTH 2
`define ADDR_WIDTH 12
`define DATA_WIDTH 16
`define COL_WIDTH 9
`define AUTO_CLOSE_BIT 10
`define MODE_CL_LSB 4
`define MODE_BL_LSB 0
`define MODE_RESET 12'h0020
`define MAX_BURST 8
`define CLK_PERIOD_PS 25000
`define PRECHARGE_TIME_NS 20
`define PRECHARGE_CYCLES ((`PRECHARGE_TIME_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define MASK_ALL 2'h3
`define MASK_NONE 2'h0
`endif

// *** sdram_pins_pkg.sv ***
// Types and small helpers shared by both ends of the DRAM pin link.
// Assumes the constants header is on the include path.
`include "sdram_pins_params.svh"
package sdram_pins_pkg;
    typedef enum logic [2:0] {CMD_NOP, CMD_ROW_OPEN, CMD_PRECHARGE, CMD_PRECHARGE_ALL,
        CMD_READ, CMD_WRITE, CMD_MODE_LOAD} host_cmd_t;
    typedef enum logic [1:0] {BANK_IDLE, BANK_ACTIVE, BANK_CLOSING} bank_state_t;

    // Burst length in words; unsupported codes fall back to one word.
    function automatic logic [3:0] burst_words(input logic [`ADDR_WIDTH-1:0] m);
        logic [2:0] code;
        code = m[`MODE_BL_LSB +: 3];
        case (code)
            3'h1: burst_words = 4'h2;
            3'h2: burst_words = 4'h4;
            3'h3: burst_words = 4'h8;
            default: burst_words = 4'h1;
        endcase
    endfunction

    // Read latency in clocks; only 2 and 3 are supported, others read as 3.
    function automatic logic [2:0] read_latency(input logic [`ADDR_WIDTH-1:0] m);
        logic [2:0] code;
        code = m[`MODE_CL_LSB +: 3];
        read_latency = (code == 3'h2) ? 3'h2 : 3'h3;
    endfunction

    // Linear burst advance that wraps inside the burst-aligned block.
    function automatic logic [`COL_WIDTH-1:0] next_col(input logic [`COL_WIDTH-1:0] c,
        input logic [3:0] bl);
        logic [`COL_WIDTH-1:0] m;
        m = {{(`COL_WIDTH-4){1'b0}}, bl - 4'h1};
        next_col = (c & ~m) | ((c + 9'h001) & m);
    endfunction
endpackage

// *** sdram_pins_props.sv ***
// Checker for the DRAM pin link, watching the shared pins of both ends.
// Assumes the testbench instantiates it beside the pin bundle, one clock.
`timescale 1ns/1ps
module sdram_pins_props
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic cs_n,
    input wire logic ras_n,
    input wire logic cas_n,
    input wire logic we_n,
    input wire logic low_byte_mask,
    input wire logic high_byte_mask,
    input wire logic [15:0] host_dq_out,
    input wire logic host_dq_oe_n,
    input wire logic [1:0] dev_dq_oe_n,
    input wire logic [15:0] data_io
);
    logic rd_cmd;
    logic wr_cmd;
    assign rd_cmd = !cs_n && ras_n && !cas_n && we_n;
    assign wr_cmd = !cs_n && ras_n && !cas_n && !we_n;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    // ----------------------------------------
    // Data bus ownership and timing
    // ----------------------------------------
    a_bus_no_clash: assert property (!(!host_dq_oe_n && dev_dq_oe_n != 2'h3))
        else $error("both ends drive the data bus");
    a_write_bus_data: assert property (!host_dq_oe_n |-> data_io == host_dq_out)
        else $error("write data not on the bus");
    a_write_drive_start: assert property ($fell(host_dq_oe_n) |-> wr_cmd)
        else $error("host drives data without a write command");
    a_write_drive_len: assert property ($fell(host_dq_oe_n) |-> ##[1:8] host_dq_oe_n)
        else $error("write drive longer than a burst");
    a_read_drive_lat: assert property ($past(dev_dq_oe_n) == 2'h3 && dev_dq_oe_n != 2'h3
        |-> $past(rd_cmd, 2) || $past(rd_cmd, 3))
        else $error("device drives without a sampled read");
    a_read_drive_len: assert property ($past(dev_dq_oe_n) == 2'h3 && dev_dq_oe_n != 2'h3
        |-> ##[1:8] dev_dq_oe_n == 2'h3)
        else $error("read drive longer than a burst");
    a_low_mask_lag: assert property (!dev_dq_oe_n[0] |-> !$past(low_byte_mask, 2))
        else $error("low byte driven while masked");
    a_high_mask_lag: assert property (!dev_dq_oe_n[1] |-> !$past(high_byte_mask, 2))
        else $error("high byte driven while masked");
endmodule

// *** testbench.sv ***
// Testbench joining both ends of the DRAM pin link through the pin bundle.
// Assumes the package, bundle and both design modules are compiled first.
`timescale 1ns/1ps
module testbench
    import sdram_pins_pkg::*;
;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic cmd_valid = 1'b0;
    logic cmd_ready;
    host_cmd_t cmd_kind = CMD_NOP;
    logic [1:0] cmd_bank = 2'h0;
    logic [11:0] cmd_addr = 12'h000;
    logic [1:0] cmd_mask = 2'h0;
    logic wr_valid = 1'b0;
    logic wr_ready;
    logic [15:0] wr_data = 16'h0000;
    logic [1:0] wr_mask = 2'h0;
    logic rd_valid;
    logic rd_ready = 1'b0;
    logic [15:0] rd_data;
    logic [3:0] bank_open;
    logic [11:0] mode_word;
    logic cmd_seen;
    int seen = 0;
    logic [15:0] d0 = 16'h0000;
    logic [15:0] d1 = 16'h0000;
    logic [1:0] m0 = 2'h0;
    logic [1:0] m1 = 2'h0;
    logic v1 = 1'b0;
    int miscompares = 0;
    int compares = 0;
    always #12.5 clk = ~clk;
    always @(posedge clk)
        if (cmd_seen === 1'b1)
            seen++;
    sdram_pins_if pins();
    sdram_host_end sdram_host_end_inst (.clk(clk), .resetn(resetn), .pins(pins),
        .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_kind(cmd_kind), .cmd_bank(cmd_bank),
        .cmd_addr(cmd_addr), .cmd_mask(cmd_mask), .wr_valid(wr_valid), .wr_ready(wr_ready),
        .wr_data(wr_data), .wr_mask(wr_mask), .rd_valid(rd_valid), .rd_ready(rd_ready),
        .rd_data(rd_data));
    sdram_device_end sdram_device_end_inst (.clk(clk), .resetn(resetn), .pins(pins),
        .bank_open(bank_open), .mode_word(mode_word), .cmd_seen(cmd_seen));
    sdram_pins_props sdram_pins_props_inst (.clk(clk), .resetn(resetn), .cs_n(pins.cs_n),
        .ras_n(pins.ras_n), .cas_n(pins.cas_n), .we_n(pins.we_n),
        .low_byte_mask(pins.low_byte_mask), .high_byte_mask(pins.high_byte_mask),
        .host_dq_out(pins.host_dq_out), .host_dq_oe_n(pins.host_dq_oe_n),
        .dev_dq_oe_n(pins.dev_dq_oe_n), .data_io(pins.data_io));
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        compares++;
        if (got !== exp)
        begin
            miscompares++;
            $display("BAD %0t %s", $time, what);
        end
    endtask
    // Write words come from d0/m0 and v1/d1/m1, set before the call.
    task automatic cmd(input host_cmd_t k, input logic [1:0] b, input logic [11:0] a,
        input logic [1:0] m);
        int n;
        n = 0;
        @(posedge clk);
        cmd_valid <= 1'b1;
        cmd_kind <= k;
        cmd_bank <= b;
        cmd_addr <= a;
        cmd_mask <= m;
        wr_valid <= (k == CMD_WRITE);
        wr_data <= d0;
        wr_mask <= m0;
        @(negedge clk);
        while (!cmd_ready && n < 200)
        begin
            n++;
            @(negedge clk);
        end
        chk({15'h0000, cmd_ready}, 16'h0001, "command not taken");
        @(posedge clk);
        cmd_valid <= 1'b0;
        wr_valid <= v1 && (k == CMD_WRITE);
        wr_data <= d1;
        wr_mask <= m1;
        @(posedge clk);
        wr_valid <= 1'b0;
    endtask
    task automatic pop(input logic [15:0] exp);
        int n;
        n = 0;
        @(negedge clk);
        while (!rd_valid && n < 50)
        begin
            n++;
            @(negedge clk);
        end
        chk(rd_data, exp, "read word wrong");
        @(posedge clk);
        rd_ready <= 1'b1;
        @(posedge clk);
        rd_ready <= 1'b0;
    endtask
    task automatic t_setup();
        @(negedge clk);
        chk({12'h000, bank_open}, 16'h0000, "banks open after reset");
        chk({4'h0, mode_word}, 16'h0020, "mode after reset");
        cmd(CMD_MODE_LOAD, 2'h0, 12'h021, 2'h0);
        repeat (3) @(posedge clk);
        chk({4'h0, mode_word}, 16'h0021, "mode load");
        for (int b = 0; b < 4; b++)
            cmd(CMD_ROW_OPEN, b[1:0], 12'hfff, 2'h0);
        repeat (3) @(negedge clk);
        chk({12'h000, bank_open}, 16'h000f, "row open per bank");
        cmd(CMD_PRECHARGE, 2'h1, 12'h3ff, 2'h0);
        repeat (4) @(negedge clk);
        chk({12'h000, bank_open}, 16'h000d, "precharge one bank");
        cmd(CMD_PRECHARGE_ALL, 2'h1, 12'h000, 2'h0);
        repeat (4) @(negedge clk);
        chk({12'h000, bank_open}, 16'h0000, "precharge all");
        // A no-operation with chip select low must not count as a command.
        cmd(CMD_NOP, 2'h0, 12'h000, 2'h0);
        repeat (3) @(negedge clk);
        chk(16'(seen), 16'h0007, "commands seen");
        $display("test setup done");
    endtask
    task automatic t_data();
        cmd(CMD_ROW_OPEN, 2'h2, 12'h123, 2'h0);
        {d0, m0, v1, d1, m1} = {16'h1234, 2'h0, 1'b1, 16'h5678, 2'h0};
        cmd(CMD_WRITE, 2'h2, 12'h004, 2'h0);
        {d0, m0, v1} = {16'h9999, 2'h1, 1'b0};
        cmd(CMD_WRITE, 2'h2, 12'h004, 2'h0);
        cmd(CMD_READ, 2'h2, 12'h004, 2'h0);
        pop(16'h9934);
        pop(16'h5678);
        cmd(CMD_READ, 2'h2, 12'h004, 2'h2);
        pop(16'h0034);
        pop(16'h0078);
        cmd(CMD_READ, 2'h2, 12'h405, 2'h0);
        pop(16'h5678);
        pop(16'h9934);
        @(negedge clk);
        chk({15'h0000, bank_open[2]}, 16'h0000, "auto close");
        $display("test data done");
    endtask
    task automatic t_fill();
        cmd(CMD_ROW_OPEN, 2'h2, 12'h123, 2'h0);
        repeat (13) cmd(CMD_READ, 2'h2, 12'h004, 2'h0);
        repeat (12) @(negedge clk);
        chk({15'h0000, cmd_ready}, 16'h0000, "read accepted with full buffer");
        repeat (13)
        begin
            pop(16'h9934);
            pop(16'h5678);
        end
        @(negedge clk);
        chk({15'h0000, rd_valid}, 16'h0000, "buffer not empty");
        $display("test fill done");
    endtask
    task automatic stop_test();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    initial
    begin
        repeat (10) @(posedge clk);
        resetn <= 1'b1;
        t_setup();
        t_data();
        t_fill();
        stop_test();
    end
    initial
    begin
        #200000;
        miscompares++;
        stop_test();
    end
endmodule
